// ---- design/mms_crc8.v ----
`timescale 1ns/100ps
`include "mms_map.vh"

module mms_crc8 (
  // Running value and new byte
  input wire [7:0] crc_in,
  input wire [7:0] data_in,
  // Updated value
  output wire [7:0] crc_out
);

  wire [7:0] stage [0:8];

  assign stage[0] = crc_in ^ data_in;

  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1)
    begin : g_bit
      assign stage[i + 1] = stage[i][7] ? ({stage[i][6:0], 1'b0} ^ `MMS_CRC_POLY)
                                        : {stage[i][6:0], 1'b0};
    end
  endgenerate

  assign crc_out = stage[8];

endmodule

// ---- design/mms_map.vh ----
`ifndef MMS_MAP_VH
`define MMS_MAP_VH

// Register byte offsets
`define MMS_OFF_CTRL 8'h00
`define MMS_OFF_ADDR 8'h04
`define MMS_OFF_STAT 8'h08
`define MMS_OFF_RXD 8'h0C
`define MMS_OFF_CRC 8'h10
`define MMS_OFF_BAUD 8'h14

// Control register fields
`define MMS_CTRL_EN 7
`define MMS_CTRL_IEN 6
`define MMS_CTRL_MAST 5
`define MMS_CTRL_RW 4

// Status register fields
`define MMS_STAT_RXIF 7
`define MMS_STAT_MATCH 6
`define MMS_STAT_CRCBF 5
`define MMS_STAT_RXBF 4
`define MMS_STAT_BB 3
`define MMS_STAT_ALIF 2
`define MMS_STAT_SRW 1

// Reset values (address value is arbitrary)
`define MMS_ADDR_RST 7'h50
`define MMS_BAUD_RST 3'h0

// Half of the smallest divider (20); the divider doubles per code step
`define MMS_HALF_BASE 12'h00A
// Packet error code polynomial x^8+x^2+x+1
`define MMS_CRC_POLY 8'h07

`endif

// ---- design/mms_serial_rx.v ----
`timescale 1ns/100ps
`include "mms_map.vh"

module mms_serial_rx #(
  parameter DIV_W = 12
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Serial clock line
  input wire scl_in,
  output reg scl_out,
  output reg scl_oe,
  // Serial data line
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe,
  // Receive interrupt request
  output reg irq
);

  localparam M_IDLE = 3'h0;
  localparam M_START = 3'h1;
  localparam M_LOW = 3'h2;
  localparam M_HIGH = 3'h3;
  localparam M_STOPA = 3'h4;
  localparam M_STOPB = 3'h5;

  reg en, ien, mast, rw;
  reg [6:0] own_addr;
  reg [2:0] baud;
  reg [7:0] rx_data, pend_byte, shift, crc_res, crc_acc, m_tx;
  reg rx_bf, rx_if, pending, match, srw, addressed, addr_phase;
  reg crc_bf, crc_load, bus_busy, stall, alif, scl_q, sda_q, m_addr;
  reg [3:0] bitcnt, m_bit;
  reg [2:0] m_state;
  reg [DIV_W-1:0] half_cnt;
  reg [31:0] next_rdata;
  reg next_err;

  wire [7:0] crc_next;
  wire [7:0] rx_byte = {shift[6:0], sda_in};
  wire acc = psel & penable & pready;
  wire wr_acc = acc & pwrite;
  wire rd_rx = acc & ~pwrite & (paddr == `MMS_OFF_RXD);
  wire rd_crc = acc & ~pwrite & (paddr == `MMS_OFF_CRC);
  wire wr_stat = wr_acc & (paddr == `MMS_OFF_STAT);
  wire scl_rise = scl_in & ~scl_q;
  wire scl_fall = ~scl_in & scl_q;
  wire start_det = scl_in & scl_q & sda_q & ~sda_in;
  wire stop_det = scl_in & scl_q & ~sda_q & sda_in;
  wire live = en & bus_busy;
  wire eighth = live & scl_rise & (bitcnt == 4'h7);
  wire ninth = live & scl_rise & (bitcnt == 4'h8);
  wire m_active = (m_state != M_IDLE);
  wire addr_hit = ~m_active & (shift[7:1] == own_addr);
  wire want_load = ninth & (addr_phase ? addr_hit : ((addressed & ~srw) | (m_active & rw)));
  wire [DIV_W-1:0] half_len = `MMS_HALF_BASE << baud;
  wire hold_high = (m_state == M_HIGH) & ~scl_in;
  wire tick = ~hold_high & (half_cnt == half_len - 1'b1);

  mms_crc8 u_crc (
    .crc_in(crc_acc),
    .data_in(rx_byte),
    .crc_out(crc_next)
  );

  // Line sampling for edge and condition detection
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end
    else
    begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  // Software control registers
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      en <= 1'b0;
      ien <= 1'b0;
      rw <= 1'b0;
      own_addr <= `MMS_ADDR_RST;
      baud <= `MMS_BAUD_RST;
    end
    else if (wr_acc)
    begin
      if (paddr == `MMS_OFF_CTRL)
      begin
        en <= pwdata[`MMS_CTRL_EN];
        ien <= pwdata[`MMS_CTRL_IEN];
        rw <= pwdata[`MMS_CTRL_RW];
      end
      else if (paddr == `MMS_OFF_ADDR)
        own_addr <= pwdata[7:1];
      else if (paddr == `MMS_OFF_BAUD)
        baud <= pwdata[2:0];
    end
  end

  // Bus state, bit counting, address match
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bus_busy <= 1'b0;
      bitcnt <= 4'h0;
      shift <= 8'h00;
      addr_phase <= 1'b0;
      addressed <= 1'b0;
      match <= 1'b0;
      srw <= 1'b0;
    end
    else if (!en)
    begin
      bus_busy <= 1'b0;
      addressed <= 1'b0;
      match <= 1'b0;
    end
    else if (start_det)
    begin
      bus_busy <= 1'b1;
      bitcnt <= 4'h0;
      addr_phase <= 1'b1;
      addressed <= 1'b0;
    end
    else if (stop_det)
    begin
      bus_busy <= 1'b0;
      addressed <= 1'b0;
    end
    else if (live & scl_rise)
    begin
      if (bitcnt != 4'h8)
        shift <= rx_byte;
      bitcnt <= (bitcnt == 4'h8) ? 4'h0 : bitcnt + 4'h1;
      if (ninth)
      begin
        addr_phase <= 1'b0;
        if (addr_phase)
        begin
          match <= addr_hit;
          addressed <= addr_hit;
          if (addr_hit)
            srw <= shift[0];
        end
        else if (addressed & ~srw)
          match <= 1'b0;
      end
    end
  end

  // Receive register, full and interrupt flags
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_data <= 8'h00;
      rx_bf <= 1'b0;
      rx_if <= 1'b0;
      pending <= 1'b0;
      pend_byte <= 8'h00;
      irq <= 1'b0;
    end
    else
    begin
      irq <= rx_if & ien;
      if (rd_rx)
        rx_bf <= 1'b0;
      if (wr_stat & ~pwdata[`MMS_STAT_RXIF])
        rx_if <= 1'b0;
      if (!en)
      begin
        rx_if <= 1'b0;
        pending <= 1'b0;
      end
      else if (want_load & rx_bf & ~rd_rx)
      begin
        pending <= 1'b1;
        pend_byte <= shift;
      end
      else if (want_load)
      begin
        rx_data <= shift;
        rx_bf <= 1'b1;
        rx_if <= 1'b1;
      end
      else if (pending & (~rx_bf | rd_rx))
      begin
        rx_data <= pend_byte;
        pending <= 1'b0;
        rx_bf <= 1'b1;
        rx_if <= 1'b1;
      end
    end
  end

  // Running packet error code over the transfer, cleared at start
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      crc_acc <= 8'h00;
      crc_res <= 8'h00;
      crc_bf <= 1'b0;
      crc_load <= 1'b0;
    end
    else
    begin
      crc_load <= eighth;
      if (rd_crc)
        crc_bf <= 1'b0;
      if (en & start_det)
        crc_acc <= 8'h00;
      else if (eighth)
      begin
        crc_acc <= crc_next;
        crc_bf <= 1'b0;
      end
      if (crc_load)
      begin
        crc_res <= crc_acc;
        crc_bf <= 1'b1;
      end
    end
  end

  // Master sequencer, slave acknowledge and clock stretch
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      m_state <= M_IDLE;
      m_bit <= 4'h0;
      m_addr <= 1'b0;
      m_tx <= 8'h00;
      half_cnt <= {DIV_W{1'b0}};
      mast <= 1'b0;
      stall <= 1'b0;
      alif <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end
    else
    begin
      if (wr_acc & (paddr == `MMS_OFF_CTRL))
        mast <= pwdata[`MMS_CTRL_MAST];
      if (wr_stat & ~pwdata[`MMS_STAT_ALIF])
        alif <= 1'b0;
      if (m_state == M_IDLE || tick)
        half_cnt <= {DIV_W{1'b0}};
      else if (!hold_high)
        half_cnt <= half_cnt + 1'b1;
      if (!en)
      begin
        m_state <= M_IDLE;
        mast <= 1'b0;
        stall <= 1'b0;
        scl_oe <= 1'b0;
        sda_oe <= 1'b0;
      end
      else
      begin
        if (stop_det)
          stall <= 1'b0;
        case (m_state)
          M_IDLE:
          begin
            if (mast & ~bus_busy & ~stall & ~(wr_acc & (paddr == `MMS_OFF_CTRL)))
            begin
              sda_oe <= 1'b1;
              m_tx <= {own_addr, rw};
              m_bit <= 4'h0;
              m_addr <= 1'b1;
              m_state <= M_START;
            end
            else
            begin
              if (scl_fall & (bitcnt == 4'h8) & live &
                  (addr_phase ? addr_hit : (addressed & ~srw)))
                sda_oe <= 1'b1;
              else if (scl_fall & (bitcnt == 4'h0))
                sda_oe <= 1'b0;
              if (pending & addressed)
              begin
                if (!scl_in)
                  scl_oe <= 1'b1;
              end
              else
                scl_oe <= 1'b0;
            end
          end
          M_START:
          begin
            if (tick)
            begin
              scl_oe <= 1'b1;
              m_state <= M_LOW;
            end
          end
          M_LOW:
          begin
            if (tick & ~((m_bit == 4'h0) & ~m_addr & pending))
            begin
              if (m_addr & (m_bit != 4'h8))
              begin
                sda_oe <= ~m_tx[7];
                m_tx <= {m_tx[6:0], 1'b0};
              end
              else if (m_bit == 4'h8)
                sda_oe <= ~m_addr & mast;
              else
                sda_oe <= 1'b0;
              scl_oe <= 1'b0;
              m_state <= M_HIGH;
            end
          end
          M_HIGH:
          begin
            if (m_addr & (m_bit != 4'h8) & ~sda_oe & scl_in & ~sda_in)
            begin
              alif <= 1'b1;
              mast <= 1'b0;
              stall <= 1'b1;
              sda_oe <= 1'b0;
              scl_oe <= 1'b0;
              m_state <= M_IDLE;
            end
            else if (tick)
            begin
              scl_oe <= 1'b1;
              if (m_bit == 4'h8)
              begin
                m_bit <= 4'h0;
                m_addr <= 1'b0;
                if (m_addr ? (sda_in | ~rw) : ~mast)
                  m_state <= M_STOPA;
                else
                  m_state <= M_LOW;
              end
              else
              begin
                m_bit <= m_bit + 4'h1;
                m_state <= M_LOW;
              end
            end
          end
          M_STOPA:
          begin
            sda_oe <= 1'b1;
            if (tick)
            begin
              scl_oe <= 1'b0;
              m_state <= M_STOPB;
            end
          end
          M_STOPB:
          begin
            if (tick)
            begin
              sda_oe <= 1'b0;
              mast <= 1'b0;
              m_state <= M_IDLE;
            end
          end
          default:
            m_state <= M_IDLE;
        endcase
      end
    end
  end

  // APB read data and answer
  always @*
  begin
    next_rdata = 32'h00000000;
    next_err = 1'b0;
    if (paddr == `MMS_OFF_CTRL)
      next_rdata[7:4] = {en, ien, mast, rw};
    else if (paddr == `MMS_OFF_ADDR)
      next_rdata[7:1] = own_addr;
    else if (paddr == `MMS_OFF_STAT)
      next_rdata[7:1] = {rx_if, match, crc_bf, rx_bf, bus_busy, alif, srw};
    else if (paddr == `MMS_OFF_RXD)
      next_rdata[7:0] = rx_data;
    else if (paddr == `MMS_OFF_CRC)
      next_rdata[7:0] = crc_res;
    else if (paddr == `MMS_OFF_BAUD)
      next_rdata[2:0] = baud;
    else
      next_err = 1'b1;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & next_err;
      if (psel & ~penable & ~pwrite)
        prdata <= next_rdata;
    end
  end

endmodule

// ---- verification/mms_bus_peer.sv ----
`timescale 1ns/100ps
module mms_bus_peer (
  // Resolved lines
  input wire scl,
  input wire sda,
  // Pull-down requests
  output logic scl_low,
  output logic sda_low
);
  localparam int HALF = 2000;
  // Set when a stretched clock never comes back
  logic stuck = 1'b0;
  initial
  begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // High phase, waiting out stretching
  task automatic clk_high();
    int n;
    n = 0;
    scl_low <= 1'b0;
    while (scl !== 1'b1 && n < 2000)
    begin
      #(HALF / 10);
      n++;
    end
    if (scl !== 1'b1)
      stuck = 1'b1;
    #(HALF);
  endtask
  task automatic start();
    sda_low <= 1'b0;
    clk_high();
    sda_low <= 1'b1;
    #(HALF);
    scl_low <= 1'b1;
    #(HALF);
  endtask
  // Most significant bit first, then acknowledge
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 8; i >= 0; i--)
    begin
      sda_low <= (i > 0) ? !b[i - 1] : 1'b0;
      #(HALF / 2);
      clk_high();
      ack = sda;
      scl_low <= 1'b1;
      #(HALF / 2);
    end
  endtask
  task automatic stop();
    sda_low <= 1'b1;
    #(HALF / 2);
    clk_high();
    sda_low <= 1'b0;
    #(HALF);
  endtask
  task automatic hold_sda(input logic v);
    sda_low <= v;
  endtask
endmodule

// ---- verification/mms_serial_rx_monitor.sv ----
`timescale 1ns/100ps
module mms_serial_rx_monitor (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Lines and interrupt
  input wire scl_in,
  input wire scl_out,
  input wire scl_oe,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe,
  input wire irq
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire rd = pready && psel && !pwrite;
  wire wr_ctrl = pready && psel && pwrite && paddr == 8'h00;
  a_ready_in_access: assert property (psel && !penable |=> pready && penable)
    else $error("pready missing in access cycle");
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_unmapped_err: assert property (pready && paddr > 8'h14 |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  a_mapped_no_err: assert property (pready && paddr <= 8'h14 && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("mapped access refused");
  a_baud_field: assert property (rd && paddr == 8'h14 |-> prdata[31:3] == 29'h0)
    else $error("divider upper bits not zero");
  a_rxd_byte: assert property (rd && paddr == 8'h0C |-> prdata[31:8] == 24'h0)
    else $error("receive data wider than a byte");
  a_drive_low_only: assert property (scl_oe || sda_oe |-> !scl_out && !sda_out)
    else $error("line driven high");
  a_disable_release: assert property (wr_ctrl && !pwdata[7] |-> ##2 (!scl_oe && !sda_oe) [*4])
    else $error("lines not released after disable");
  a_irq_masked: assert property (wr_ctrl && !pwdata[6] |-> ##2 !irq)
    else $error("interrupt while disabled");
endmodule

// ---- verification/mms_serial_rx_tb.sv ----
`timescale 1ns/100ps
module mms_serial_rx_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  wire [31:0] prdata;
  wire pready, pslverr, scl_out, scl_oe, sda_out, sda_oe, irq;
  wire peer_scl_low, peer_sda_low;
  wire scl_in = !(scl_oe || peer_scl_low);
  wire sda_in = !(sda_oe || peer_sda_low);
  int failures = 0;
  int total_checks = 0;
  int cnt;
  logic [31:0] rv;
  logic ack;
  logic [7:0] crc;
  logic [7:0] ra [6] = '{8'h00, 8'h04, 8'h14, 8'h14, 8'h08, 8'h18};
  logic [31:0] rw [6] = '{32'hC0, 32'hA0, 32'hFFFFFFF9, 32'h0, 32'hFF, 32'h55};
  logic [31:0] re [6] = '{32'hC0, 32'hA0, 32'h1, 32'h0, 32'h0, 32'h0};
  always #20 pclk = ~pclk;
  mms_serial_rx u_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .scl_in, .scl_out, .scl_oe, .sda_in, .sda_out, .sda_oe, .irq);
  mms_bus_peer u_peer (.scl(scl_in), .sda(sda_in), .scl_low(peer_scl_low),
    .sda_low(peer_sda_low));
  task automatic give_verdict();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rv = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      failures++;
      give_verdict();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    check(rv & m, e);
  endtask
  task automatic reset_dut();
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    for (int i = 0; i < 8; i++)
      r = r[7] ? ({r[6:0], 1'b0} ^ 8'h07) : {r[6:0], 1'b0};
    return r;
  endfunction
  initial
  begin
    reset_dut();
    for (int i = 0; i < 6; i++)
    begin
      apb(ra[i], 1'b1, rw[i]);
      rd(ra[i], 32'hFFFFFFFF, re[i]);
    end
    reset_dut();
    rd(8'h14, 32'hFFFFFFFF, 32'h0);
    rd(8'h08, 32'hFFFFFFFF, 32'h0);
    apb(8'h00, 1'b1, 32'hC0);
    // Slave receive: address, then a byte held behind it
    u_peer.start();
    u_peer.send_byte(8'hA0, ack);
    check({31'h0, ack}, 32'h0);
    rd(8'h08, 32'hFF, 32'hF8);
    check({31'h0, irq}, 32'h1);
    crc = crc8(8'h00, 8'hA0);
    rd(8'h10, 32'hFF, {24'h0, crc});
    rd(8'h08, 32'h20, 32'h0);
    fork
      u_peer.send_byte(8'h3C, ack);
    join_none
    repeat (1500) @(posedge pclk);
    check({31'h0, scl_oe}, 32'h1);
    rd(8'h0C, 32'hFFFFFFFF, 32'hA0);
    repeat (4) @(posedge pclk);
    rd(8'h08, 32'h50, 32'h10);
    rd(8'h0C, 32'hFFFFFFFF, 32'h3C);
    wait fork;
    check({31'h0, ack}, 32'h0);
    rd(8'h10, 32'hFF, {24'h0, crc8(crc, 8'h3C)});
    rd(8'h08, 32'h30, 32'h0);
    u_peer.stop();
    rd(8'h08, 32'h08, 32'h0);
    // Master loses arbitration on its first one bit
    apb(8'h08, 1'b1, 32'h0);
    // Divider 320: about 78 kHz serial clock at 25 MHz
    apb(8'h14, 1'b1, 32'h4);
    apb(8'h00, 1'b1, 32'hB0);
    rv = 32'h0;
    for (int n = 0; n < 50 && rv[3] !== 1'b1; n++)
      apb(8'h08, 1'b0, 32'h0);
    u_peer.hold_sda(1'b1);
    // Clock low phase lasts half the divider
    cnt = 0;
    while (scl_oe !== 1'b1 && cnt < 400)
    begin
      @(posedge pclk);
      cnt++;
    end
    cnt = 0;
    while (scl_oe === 1'b1 && cnt < 400)
    begin
      @(posedge pclk);
      cnt++;
    end
    check(cnt, 32'hA0);
    repeat (100) @(posedge pclk);
    check({30'h0, scl_oe, sda_oe}, 32'h0);
    rd(8'h00, 32'h20, 32'h0);
    repeat (300) @(posedge pclk);
    rd(8'h08, 32'h0C, 32'h0C);
    apb(8'h00, 1'b1, 32'h0);
    rd(8'h08, 32'h08, 32'h0);
    u_peer.hold_sda(1'b0);
    apb(8'h00, 1'b1, 32'h80);
    u_peer.start();
    u_peer.send_byte(8'hA0, ack);
    check({31'h0, ack}, 32'h0);
    u_peer.stop();
    check({31'h0, u_peer.stuck}, 32'h0);
    give_verdict();
  end
endmodule
bind mms_serial_rx mms_serial_rx_monitor u_mon (.pclk, .presetn, .paddr, .psel, .penable,
  .pwrite, .pwdata, .prdata, .pready, .pslverr, .scl_in, .scl_out, .scl_oe, .sda_in,
  .sda_out, .sda_oe, .irq);
